// File: common/slext_pkg.sv
// Constants and types for the link status-extension block
package slext_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned RCV_TMO_S = 25;
   localparam int unsigned OPEN_TMO_S = 3;
   localparam logic [2:0] SEVEN_ONES = 3'h7;
   localparam logic [7:0] FLAG_SEQ = 8'h7E;
   // Status bits are numbered from the MSB: bit 0 is position 7
   localparam int unsigned P_B0 = 7;
   localparam int unsigned P_B1 = 6;
   localparam int unsigned P_B2 = 5;
   localparam int unsigned P_B3 = 4;
   localparam int unsigned P_B4 = 3;
   localparam int unsigned P_B5 = 2;
   localparam int unsigned P_B6 = 1;
   localparam int unsigned P_B7 = 0;
   localparam int unsigned NEXT = 5;
   // Flags that also raise the return-request interlock, per extension
   localparam logic [7:0] ILK_MASK [1:NEXT] = '{8'h02, 8'h72, 8'h7F, 8'h2F, 8'h49};
   // Status flag byte code per extension, before the interlock bit
   localparam logic [7:0] SEL_CODE [1:NEXT] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04};
   localparam logic [7:0] ILK_CODE = 8'h80;
   // Register byte offsets
   localparam logic [5:0] A_FLAG = 6'h00;
   localparam logic [5:0] A_SEL = 6'h04;
   localparam logic [5:0] A_EXT1 = 6'h08;
   localparam logic [5:0] A_EXT5 = 6'h18;
   localparam logic [5:0] A_CTRL = 6'h1C;
   localparam int unsigned CTRL_N_LSB = 0;
   localparam int unsigned N_W = 4;
   localparam int unsigned CTRL_OPEN = 8;
   localparam int unsigned CTRL_BUSY = 9;
   localparam logic [3:0] N_RST = 4'h3;
   localparam int unsigned NCNT = 3;
   typedef enum logic {SLEXT_OPEN_IDLE, SLEXT_OPEN_WAIT} slext_open_t;
endpackage

// File: common/slext_line_if.sv
// Line pins and line events shared by the core and the line monitor
`timescale 1ns/1ps
interface slext_line_if;
   logic [5:0] pins;
   logic tx_active;
   logic rts_on;
   logic carrier_s;
   logic dsr_s;
   logic mrdy_s;
   logic flag_seen;
   logic seven_ones;
   logic cts_fault;
   modport core (output pins, tx_active, rts_on,
      input carrier_s, dsr_s, mrdy_s, flag_seen, seven_ones, cts_fault);
   modport mon (input pins, tx_active, rts_on,
      output carrier_s, dsr_s, mrdy_s, flag_seen, seven_ones, cts_fault);
endinterface

// File: verilog/slext_line_mon.sv
// Pin synchroniser, flag and abort detector, clear-to-send watch
`timescale 1ns/1ps
module slext_line_mon (
   input wire logic clk,
   input wire logic srst,
   slext_line_if.mon lif
);
   // pins: 0 rx data, 1 rx clock, 2 carrier, 3 cts, 4 dsr, 5 modem ready
   logic [5:0] s1_q;
   logic [5:0] s2_q;
   logic rxc_q;
   logic [6:0] sh_q;
   logic [2:0] ones_q;
   logic in_frame_q;
   logic cts_bad_q;
   logic bit_en;
   logic cts_bad;

   always_ff @(posedge clk) begin
      if (srst) begin
         s1_q <= 6'h00;
         s2_q <= 6'h00;
         rxc_q <= 1'b0;
      end else begin
         s1_q <= lif.pins;
         s2_q <= s1_q;
         rxc_q <= s2_q[1];
      end
   end

   assign bit_en = s2_q[1] && !rxc_q;
   assign lif.carrier_s = s2_q[2];
   assign lif.dsr_s = s2_q[4];
   assign lif.mrdy_s = s2_q[5];

   always_ff @(posedge clk) begin
      if (srst) begin
         sh_q <= 7'h00;
         ones_q <= 3'h0;
         in_frame_q <= 1'b0;
         lif.flag_seen <= 1'b0;
         lif.seven_ones <= 1'b0;
      end else begin
         lif.flag_seen <= 1'b0;
         lif.seven_ones <= 1'b0;
         if (bit_en) begin
            sh_q <= {sh_q[5:0], s2_q[0]};
            ones_q <= s2_q[0] ? ones_q + 3'h1 : 3'h0;
            if ({sh_q, s2_q[0]} == slext_pkg::FLAG_SEQ) begin
               lif.flag_seen <= 1'b1;
               in_frame_q <= 1'b1;
            end else if (s2_q[0] && ones_q == slext_pkg::SEVEN_ONES - 3'h1) begin
               lif.seven_ones <= in_frame_q;
               in_frame_q <= 1'b0;
            end
         end
      end
   end

   assign cts_bad = lif.tx_active && lif.rts_on && !s2_q[3];

   always_ff @(posedge clk) begin
      if (srst) begin
         cts_bad_q <= 1'b0;
         lif.cts_fault <= 1'b0;
      end else begin
         cts_bad_q <= cts_bad;
         lif.cts_fault <= cts_bad && !cts_bad_q;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   AST_CTS_DROP: assert property (cts_bad && !cts_bad_q |=> lif.cts_fault ##1 !lif.cts_fault)
      else $error("cts drop not reported once");
endmodule

// File: verilog/slext_top.sv
// Status-extension flag logic of the link adapter with its register slave
`timescale 1ns/1ps
//
// Contract
// - Extension bit 0 is the interlock; every interlocking flag also sets it.
// - Status byte 40/C0..04/84 selects extension 1..5; top bit is interlock.
// - Extension 1 bit 1 after N poll retries with no response at all.
// - Extension 1 bit 2 when line active 25 seconds without flags.
// - Extension 1 bit 3 when open waits 3 seconds for modem and DSR.
// - Extension 1 bit 6 and interlock on offline unit coming online.
// - Extension 2 flag on a received frame failing its check.
// - Extension 2 flag on invalid address; bit 4 gives the reason.
// - Seven ones abort the frame and set sequence error (extension 2 bit 3); check error is not set.
// - Extension 2 flag when clear-to-send drops while sending with RTS.
// - Extension 3 bit 1 on NSA to DISC; control block left untouched.
// - Extension 3 bit 2 on NSA to SNRM, bit 6 on NSA to SIM.
// - Extension 3 bit 3 on ROL, bit 7 on RQI.
// - Extension 3 bit 4 on a command reject.
// - Extension 3 bit 5 on duplicate set-mode answers or unsolicited NSA.
// - Extension 4 bit 1 whenever a primary-busy command is sent.
// - Extension 4 bit 2 after N contact polls, bit 3 after N writes fail.
// - Extension 4 bit 4 on lost data; bit 7 too when no buffer.
// - Extension 4 bit 5 on short info frame, bit 6 on bad send count.
// - Extension 5 flag when a moved control unit sends a valid frame.
// - Extension 5 flag on good frame with receive count out of range.
// - Extension 5 flags on unknown command byte or unknown response.
module slext_top #(
   parameter int unsigned SEC_CYCLES = slext_pkg::CLK_HZ
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [5:0] avm_address,
   input wire logic avm_read,
   input wire logic avm_write,
   input wire logic [31:0] avm_writedata,
   input wire logic [3:0] avm_byteenable,
   output logic [31:0] avm_readdata,
   output logic avm_waitrequest,
   input wire logic rx_data_pin,
   input wire logic rx_clk_pin,
   input wire logic carrier_pin,
   input wire logic cts_pin,
   input wire logic dsr_pin,
   input wire logic modem_ready_pin,
   input wire logic tx_active,
   input wire logic rts_on,
   input wire logic ev_poll_tmo,
   input wire logic ev_poll_resp,
   input wire logic ev_unit_online,
   input wire logic ev_crc_err,
   input wire logic ev_bad_addr,
   input wire logic bad_addr_range,
   input wire logic ev_nsa_disc,
   input wire logic ev_nsa_snrm,
   input wire logic ev_nsa_sim,
   input wire logic ev_rol,
   input wire logic ev_rqi,
   input wire logic ev_cmd_rej,
   input wire logic ev_dup_resp,
   input wire logic ev_unsol_nsa,
   input wire logic ev_busy_sent,
   input wire logic ev_cpoll_tmo,
   input wire logic ev_cpoll_ack,
   input wire logic ev_iwr_tmo,
   input wire logic ev_iwr_ack,
   input wire logic ev_lost_nobuf,
   input wire logic ev_lost_rdexh,
   input wire logic ev_short_i,
   input wire logic ev_ns_err,
   input wire logic ev_cu_moved,
   input wire logic ev_nr_err,
   input wire logic ev_bad_resp,
   input wire logic ev_bad_cmd,
   output logic [7:0] status_flag_byte,
   output logic [7:0] status_extension_byte,
   output logic frame_abort
);
   localparam int unsigned RCV_LIM = slext_pkg::RCV_TMO_S * SEC_CYCLES;
   localparam int unsigned OPEN_LIM = slext_pkg::OPEN_TMO_S * SEC_CYCLES;

   slext_line_if lif ();

   slext_line_mon u_mon (
      .clk(clk),
      .srst(srst),
      .lif(lif.mon)
   );

   assign lif.pins = {modem_ready_pin, dsr_pin, cts_pin, carrier_pin, rx_clk_pin, rx_data_pin};
   assign lif.tx_active = tx_active;
   assign lif.rts_on = rts_on;

   // Maps a byte address to an extension number, 0 when not one
   function automatic logic [2:0] ext_of(input logic [5:0] a);
      logic [5:0] d;
      d = a - slext_pkg::A_EXT1;
      if (a < slext_pkg::A_EXT1 || a > slext_pkg::A_EXT5 || a[1:0] != 2'h0) begin
         return 3'h0;
      end
      return d[4:2] + 3'h1;
   endfunction

   logic [7:0] ext_q [1:slext_pkg::NEXT];
   logic [7:0] set_v [1:slext_pkg::NEXT];
   logic [7:0] clr_v [1:slext_pkg::NEXT];
   logic [3:0] retry_n_q;
   logic [3:0] rcnt_q [0:slext_pkg::NCNT-1];
   logic [slext_pkg::NCNT-1:0] r_tmo;
   logic [slext_pkg::NCNT-1:0] r_ack;
   logic [slext_pkg::NCNT-1:0] r_hit;
   logic [31:0] rcv_cnt_q;
   logic [31:0] open_cnt_q;
   logic rcv_hit;
   logic open_hit;
   logic open_go;
   logic wr_take;
   slext_pkg::slext_open_t open_st_q;

   // Bus: one wait cycle, then the request is answered
   assign wr_take = avm_write && !avm_waitrequest;
   assign open_go = wr_take && avm_byteenable[1] && avm_address == slext_pkg::A_CTRL
      && avm_writedata[slext_pkg::CTRL_OPEN];

   always_ff @(posedge clk) begin
      if (srst) begin
         avm_waitrequest <= 1'b1;
         avm_readdata <= 32'h0000_0000;
      end else if ((avm_read || avm_write) && avm_waitrequest) begin
         avm_waitrequest <= 1'b0;
         avm_readdata <= 32'h0000_0000;
         if (avm_read) begin
            if (avm_address == slext_pkg::A_FLAG) begin
               avm_readdata[7:0] <= status_flag_byte;
            end else if (avm_address == slext_pkg::A_SEL) begin
               avm_readdata[7:0] <= status_extension_byte;
            end else if (avm_address == slext_pkg::A_CTRL) begin
               avm_readdata[slext_pkg::CTRL_N_LSB +: slext_pkg::N_W] <= retry_n_q;
               avm_readdata[slext_pkg::CTRL_BUSY] <= open_st_q == slext_pkg::SLEXT_OPEN_WAIT;
            end else if (ext_of(avm_address) != 3'h0) begin
               avm_readdata[7:0] <= ext_q[ext_of(avm_address)];
            end
         end
      end else begin
         avm_waitrequest <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         retry_n_q <= slext_pkg::N_RST;
      end else if (wr_take && avm_byteenable[0] && avm_address == slext_pkg::A_CTRL) begin
         retry_n_q <= avm_writedata[slext_pkg::CTRL_N_LSB +: slext_pkg::N_W];
      end
   end

   // retry counters: poll, contact poll, info write
   assign r_tmo = {ev_iwr_tmo, ev_cpoll_tmo, ev_poll_tmo};
   assign r_ack = {ev_iwr_ack, ev_cpoll_ack, ev_poll_resp};

   genvar gi;
   generate
      for (gi = 0; gi < slext_pkg::NCNT; gi++) begin : g_retry
         assign r_hit[gi] = r_tmo[gi] && !r_ack[gi]
            && {1'b0, rcnt_q[gi]} + 5'h01 >= {1'b0, retry_n_q};
         always_ff @(posedge clk) begin
            if (srst || r_ack[gi] || r_hit[gi]) begin
               rcnt_q[gi] <= 4'h0;
            end else if (r_tmo[gi]) begin
               rcnt_q[gi] <= rcnt_q[gi] + 4'h1;
            end
         end
      end
   endgenerate

   // idle-receive timer, restarted by any flag or carrier loss
   assign rcv_hit = lif.carrier_s && !lif.flag_seen && rcv_cnt_q == RCV_LIM - 1;

   always_ff @(posedge clk) begin
      if (srst || !lif.carrier_s || lif.flag_seen || rcv_hit) begin
         rcv_cnt_q <= 32'h0000_0000;
      end else begin
         rcv_cnt_q <= rcv_cnt_q + 32'h0000_0001;
      end
   end

   // open waits for modem ready and DSR together
   assign open_hit = open_st_q == slext_pkg::SLEXT_OPEN_WAIT
      && !(lif.dsr_s && lif.mrdy_s) && open_cnt_q == OPEN_LIM - 1;

   always_ff @(posedge clk) begin
      if (srst) begin
         open_st_q <= slext_pkg::SLEXT_OPEN_IDLE;
         open_cnt_q <= 32'h0000_0000;
      end else begin
         case (open_st_q)
            slext_pkg::SLEXT_OPEN_IDLE: begin
               open_cnt_q <= 32'h0000_0000;
               if (open_go) begin
                  open_st_q <= slext_pkg::SLEXT_OPEN_WAIT;
               end
            end
            slext_pkg::SLEXT_OPEN_WAIT: begin
               open_cnt_q <= open_cnt_q + 32'h0000_0001;
               if ((lif.dsr_s && lif.mrdy_s) || open_hit) begin
                  open_st_q <= slext_pkg::SLEXT_OPEN_IDLE;
               end
            end
            default: begin
               open_st_q <= slext_pkg::SLEXT_OPEN_IDLE;
            end
         endcase
      end
   end

   // Event to flag mapping; bit positions count from the MSB
   always_comb begin
      for (int n = 1; n <= slext_pkg::NEXT; n++) begin
         set_v[n] = 8'h00;
         clr_v[n] = 8'h00;
         if (wr_take && avm_byteenable[0] && ext_of(avm_address) == n[2:0]) begin
            clr_v[n] = avm_writedata[7:0];
         end
      end
      set_v[1][slext_pkg::P_B1] = r_hit[0];
      set_v[1][slext_pkg::P_B2] = rcv_hit;
      set_v[1][slext_pkg::P_B3] = open_hit;
      set_v[1][slext_pkg::P_B6] = ev_unit_online;
      set_v[2][slext_pkg::P_B1] = ev_crc_err;
      set_v[2][slext_pkg::P_B2] = ev_bad_addr;
      set_v[2][slext_pkg::P_B4] = ev_bad_addr && bad_addr_range;
      clr_v[2][slext_pkg::P_B4] = clr_v[2][slext_pkg::P_B4] | ev_bad_addr;
      set_v[2][slext_pkg::P_B3] = lif.seven_ones;
      set_v[2][slext_pkg::P_B6] = lif.cts_fault;
      // disconnect answered; no control block clear is issued
      set_v[3][slext_pkg::P_B1] = ev_nsa_disc;
      set_v[3][slext_pkg::P_B2] = ev_nsa_snrm;
      set_v[3][slext_pkg::P_B6] = ev_nsa_sim;
      set_v[3][slext_pkg::P_B3] = ev_rol;
      set_v[3][slext_pkg::P_B7] = ev_rqi;
      set_v[3][slext_pkg::P_B4] = ev_cmd_rej;
      set_v[3][slext_pkg::P_B5] = ev_dup_resp || ev_unsol_nsa;
      set_v[4][slext_pkg::P_B1] = ev_busy_sent;
      set_v[4][slext_pkg::P_B2] = r_hit[1];
      set_v[4][slext_pkg::P_B3] = r_hit[2];
      set_v[4][slext_pkg::P_B4] = ev_lost_nobuf || ev_lost_rdexh;
      set_v[4][slext_pkg::P_B7] = ev_lost_nobuf;
      set_v[4][slext_pkg::P_B5] = ev_short_i;
      set_v[4][slext_pkg::P_B6] = ev_ns_err;
      set_v[5][slext_pkg::P_B1] = ev_cu_moved;
      set_v[5][slext_pkg::P_B4] = ev_nr_err;
      set_v[5][slext_pkg::P_B6] = ev_bad_resp;
      set_v[5][slext_pkg::P_B7] = ev_bad_cmd;
      for (int n = 1; n <= slext_pkg::NEXT; n++) begin
         set_v[n][slext_pkg::P_B0] = |(set_v[n] & slext_pkg::ILK_MASK[n]);
      end
   end

   // Set wins over a same-cycle write-one-to-clear
   always_ff @(posedge clk) begin
      for (int n = 1; n <= slext_pkg::NEXT; n++) begin
         if (srst) begin
            ext_q[n] <= 8'h00;
         end else begin
            ext_q[n] <= (ext_q[n] & ~clr_v[n]) | set_v[n];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         status_flag_byte <= 8'h00;
         status_extension_byte <= 8'h00;
      end else begin
         status_flag_byte <= 8'h00;
         status_extension_byte <= 8'h00;
         for (int n = slext_pkg::NEXT; n >= 1; n--) begin
            if (ext_q[n] != 8'h00) begin
               status_flag_byte <= slext_pkg::SEL_CODE[n]
                  | (ext_q[n][slext_pkg::P_B0] ? slext_pkg::ILK_CODE : 8'h00);
               status_extension_byte <= ext_q[n];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         frame_abort <= 1'b0;
      end else begin
         frame_abort <= lif.seven_ones;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   AST_ONLINE_ILK: assert property (ev_unit_online |=> ext_q[1][1] && ext_q[1][7])
      else $error("online flag or interlock missing");
   AST_SELECT: assert property (ext_q[1] != 8'h00 |=> status_flag_byte[6:0] == 7'h40)
      else $error("extension 1 not selected");
   AST_TOPBIT: assert property (ext_q[3][7] && ext_q[1] == 8'h00 && ext_q[2] == 8'h00
      |=> status_flag_byte == 8'h90)
      else $error("interlock top bit wrong");
   // A response restarts the count and never raises the flag, even beside a timeout
   AST_POLL_CLR: assert property (ev_poll_resp
      |=> rcnt_q[0] == 4'h0 && !$rose(ext_q[1][6]))
      else $error("poll response did not restart retries");
   AST_RCV_IDLE: assert property (!lif.carrier_s |=> rcv_cnt_q == 32'h0000_0000)
      else $error("idle timer ran without carrier");
   // A timeout flag set earlier may still stand, so only a rising timeout flag is wrong
   AST_OPEN_DONE: assert property (open_st_q == slext_pkg::SLEXT_OPEN_WAIT
      && lif.dsr_s && lif.mrdy_s |=> open_st_q == slext_pkg::SLEXT_OPEN_IDLE
      && !$rose(ext_q[1][4]))
      else $error("open wait did not end on ready");
   AST_ABORT: assert property (lif.seven_ones |=> frame_abort && ext_q[2][4] && ext_q[2][7]
      ##1 !frame_abort)
      else $error("abort not reported");
   AST_REASON: assert property (ev_bad_addr |=> ext_q[2][5]
      && ext_q[2][3] == $past(bad_addr_range))
      else $error("address reason wrong");
   AST_NOBUF: assert property (ev_lost_nobuf |=> ext_q[4][3] && ext_q[4][0])
      else $error("no-buffer loss not flagged");
   AST_BUS_ANS: assert property ((avm_read || avm_write) && avm_waitrequest
      |=> !avm_waitrequest ##1 avm_waitrequest)
      else $error("bus answer timing wrong");
endmodule

// File: sim/slext_far_model.sv
// Far-side model: control unit receive line and modem signals
`timescale 1ns/1ps
module slext_far_model (
   output logic rx_data,
   output logic rx_clk,
   output logic carrier,
   output logic cts,
   output logic dsr,
   output logic mrdy
);
   // Bit half period kept unrelated in phase to the system clock
   localparam time HALF = 430ns;
   initial begin
      rx_data = 1'b0;
      rx_clk = 1'b0;
      carrier = 1'b0;
      cts = 1'b1;
      dsr = 1'b1;
      mrdy = 1'b1;
   end
   // serial bits
   // MSB first; the line clock stands still between frames
   task automatic send(input logic [7:0] b, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         rx_data = b[i];
         #HALF rx_clk = 1'b1;
         #HALF rx_clk = 1'b0;
      end
      rx_data = ~rx_data;
   endtask
   // steady clear-to-send
   // Only dropped when the bench asks for a fault
   task automatic cts_glitch;
      cts = 1'b0;
      #300ns cts = 1'b1;
   endtask
   task automatic modem(input logic c, input logic d, input logic m);
      carrier = c;
      dsr = d;
      mrdy = m;
   endtask
endmodule

// File: sim/test_slext_top.sv
// Self-checking bench for the link status-extension block
`timescale 1ns/1ps
module test_slext_top;
   // Entry: event index (bit 7 = address out of range), extension, expected byte
   localparam logic [19:0] TBL [0:20] = '{
      20'h02_1_82, 20'h03_2_C0, 20'h04_2_A0, 20'h84_2_A8, 20'h05_3_C0, 20'h06_3_A0,
      20'h07_3_82, 20'h08_3_90, 20'h09_3_81, 20'h0A_3_88, 20'h0B_3_84, 20'h0C_3_84,
      20'h0D_4_40, 20'h12_4_89, 20'h13_4_88, 20'h14_4_84, 20'h15_4_82, 20'h16_5_C0,
      20'h17_5_88, 20'h18_5_02, 20'h19_5_81};
   logic clk, srst, avm_read, avm_write, avm_waitrequest, frame_abort;
   logic [5:0] avm_address;
   logic [31:0] avm_writedata, avm_readdata, rdata;
   logic [3:0] avm_byteenable;
   logic [25:0] ev;
   logic bad_addr_range, tx_active, rts_on;
   logic rx_data, rx_clk, carrier, cts, dsr, mrdy;
   logic [7:0] status_flag_byte, status_extension_byte;
   int n_mismatch = 0;
   int check_count = 0;
   int n_abort = 0;

   // Short second keeps the 25 s and 3 s timers at 500 and 60 cycles
   slext_top #(.SEC_CYCLES(20)) i_dut (.clk(clk), .srst(srst), .avm_address(avm_address),
      .avm_read(avm_read), .avm_write(avm_write), .avm_writedata(avm_writedata),
      .avm_byteenable(avm_byteenable), .avm_readdata(avm_readdata),
      .avm_waitrequest(avm_waitrequest), .rx_data_pin(rx_data), .rx_clk_pin(rx_clk),
      .carrier_pin(carrier), .cts_pin(cts), .dsr_pin(dsr), .modem_ready_pin(mrdy),
      .tx_active(tx_active), .rts_on(rts_on), .ev_poll_tmo(ev[0]), .ev_poll_resp(ev[1]),
      .ev_unit_online(ev[2]), .ev_crc_err(ev[3]), .ev_bad_addr(ev[4]),
      .bad_addr_range(bad_addr_range), .ev_nsa_disc(ev[5]), .ev_nsa_snrm(ev[6]),
      .ev_nsa_sim(ev[7]), .ev_rol(ev[8]), .ev_rqi(ev[9]), .ev_cmd_rej(ev[10]),
      .ev_dup_resp(ev[11]), .ev_unsol_nsa(ev[12]), .ev_busy_sent(ev[13]),
      .ev_cpoll_tmo(ev[14]), .ev_cpoll_ack(ev[15]), .ev_iwr_tmo(ev[16]), .ev_iwr_ack(ev[17]),
      .ev_lost_nobuf(ev[18]), .ev_lost_rdexh(ev[19]), .ev_short_i(ev[20]),
      .ev_ns_err(ev[21]), .ev_cu_moved(ev[22]), .ev_nr_err(ev[23]), .ev_bad_resp(ev[24]),
      .ev_bad_cmd(ev[25]), .status_flag_byte(status_flag_byte),
      .status_extension_byte(status_extension_byte), .frame_abort(frame_abort));

   slext_far_model i_far (.rx_data(rx_data), .rx_clk(rx_clk), .carrier(carrier), .cts(cts),
      .dsr(dsr), .mrdy(mrdy));

   always #50 clk = ~clk;

   // Counts high cycles, so a stretched pulse shows up as an extra count
   always @(posedge clk) begin
      if (frame_abort === 1'b1) n_abort <= n_abort + 1;
   end

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Entered just after a rising edge; holds until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      avm_address <= a;
      avm_writedata <= d;
      avm_read <= ~w;
      avm_write <= w;
      do @(posedge clk); while (avm_waitrequest !== 1'b0);
      rdata = avm_readdata;
      avm_read <= 1'b0;
      avm_write <= 1'b0;
      // Let an edge pass so a following call never re-drives the strobe in this step
      @(posedge clk);
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdata, e);
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic pulse(input int i);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev <= '0;
      @(posedge clk);
   endtask

   task automatic fire(input logic [19:0] e);
      logic [5:0] a;
      logic [7:0] sel;
      a = 6'h08 + {e[11:8] - 4'h1, 2'b00};
      sel = (8'h80 >> e[11:8]) | {e[7], 7'h0};
      bad_addr_range <= e[19];
      pulse(int'(e[16:12]));
      repeat (2) @(posedge clk);
      chk(status_extension_byte, e[7:0]);
      chk(status_flag_byte, sel);
      rd(a, {24'h0, e[7:0]});
      rd(6'h04, {24'h0, e[7:0]});
      wr(a, 32'hFF);
      rd(a, 32'h0);
   endtask

   // An acknowledge in the middle restarts the count
   task automatic retry(input int t, input int a, input logic [5:0] adr, input logic [7:0] e,
         input int n);
      for (int k = 0; k < 2 * n - 1; k++) begin
         pulse((k == n - 1) ? a : t);
      end
      rd(adr, 32'h0);
      pulse(t);
      rd(adr, {24'h0, e});
      wr(adr, 32'hFF);
   endtask

   initial begin
      clk = 1'b0;
      {srst, avm_read, avm_write, tx_active, rts_on, bad_addr_range} = 6'b100000;
      {avm_address, avm_writedata, ev} = '0;
      avm_byteenable = 4'hF;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(6'h1C, 32'h3);
      rd(6'h00, 32'h0);
      rd(6'h3C, 32'h0);
      retry(0, 1, 6'h08, 8'h40, 3);
      retry(14, 15, 6'h14, 8'hA0, 3);
      wr(6'h1C, 32'h2);
      rd(6'h1C, 32'h2);
      retry(16, 17, 6'h14, 8'h10, 2);
      for (int i = 0; i < 21; i++) begin
         fire(TBL[i]);
      end
      ev <= 26'h2000008;
      @(posedge clk);
      ev <= '0;
      repeat (3) @(posedge clk);
      chk(status_flag_byte, 8'hA0);
      wr(6'h0C, 32'hFF);
      repeat (3) @(posedge clk);
      chk(status_extension_byte, 8'h81);
      chk(status_flag_byte, 8'h84);
      wr(6'h18, 32'hFF);
      i_far.modem(1'b1, 1'b1, 1'b1);
      repeat (480) @(posedge clk);
      rd(6'h08, 32'h0);
      repeat (40) @(posedge clk);
      rd(6'h08, 32'h20);
      i_far.send(8'h7E, 8);
      i_far.send(8'hFC, 8);
      repeat (20) @(posedge clk);
      chk(n_abort, 0);
      i_far.send(8'h7E, 8);
      i_far.send(8'hFF, 7);
      repeat (20) @(posedge clk);
      chk(n_abort, 1);
      rd(6'h0C, 32'h90);
      wr(6'h0C, 32'hFF);
      i_far.modem(1'b0, 1'b1, 1'b1);
      repeat (4) @(posedge clk);
      wr(6'h08, 32'hFF);
      wr(6'h1C, 32'h103);
      repeat (80) @(posedge clk);
      rd(6'h08, 32'h0);
      i_far.modem(1'b0, 1'b0, 1'b1);
      repeat (4) @(posedge clk);
      wr(6'h1C, 32'h103);
      rd(6'h1C, 32'h203);
      repeat (40) @(posedge clk);
      rd(6'h08, 32'h0);
      repeat (40) @(posedge clk);
      rd(6'h08, 32'h10);
      tx_active <= 1'b1;
      @(posedge clk);
      i_far.cts_glitch;
      repeat (15) @(posedge clk);
      rd(6'h0C, 32'h0);
      rts_on <= 1'b1;
      @(posedge clk);
      i_far.cts_glitch;
      repeat (15) @(posedge clk);
      rd(6'h0C, 32'h82);
      end_sim;
   end

   // The sequence needs about 1500 cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      end_sim;
   end
endmodule
